// >>> src/rbms_top.sv
// Purpose: reset indication, strap capture and segment port steering
// Assumes: 250 MHz clock, asynchronous active-low reset
// Notes:   reset input and straps are pins and are synchronised here
`timescale 1ns/10ps
module rbms_top
    import rbms_pkg::*;
(
    // clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  reset_n_i,
    input  wire logic                  clk_en_i,
    // pins
    input  wire logic                  external_reset_input_n_i,
    input  wire logic                  bus_active_select_i,
    input  wire logic                  bus_config_select_hi_i,
    input  wire logic                  bus_config_select_lo_i,
    // reset sources and end of init from the core
    input  wire logic                  sw_reset_i,
    input  wire logic                  wdt_reset_i,
    input  wire logic                  end_of_init_instruction_i,
    // segment port control
    input  wire logic [1:0]            port_dir_i,
    input  wire logic [1:0]            port_data_i,
    input  wire logic                  seg_addr_low_i,
    input  wire logic                  seg_addr_high_i,
    // outputs
    output logic                       internal_reset_indication_n_o,
    output logic                       core_reset_n_o,
    output rbms_pkg::rbms_mode_e       bus_mode_o,
    output logic                       ext_bus_o,
    output logic                       mode_reserved_o,
    output logic [1:0]                 segment_port_out_o,
    output logic [1:0]                 segment_port_oe_o
);
    import rbms_pkg::*;

    // three-flop synchronisers for reset pin and straps
    logic [2:0] rst_sync_q;
    logic [2:0] cfg_s1_q;
    logic [2:0] cfg_s2_q;
    logic [2:0] cfg_s3_q;
    logic       rst_lvl_q;

    // the first stage is read only by the second
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_sync_q <= 3'h7;
            cfg_s1_q   <= CFG_RESET_VAL;
            cfg_s2_q   <= CFG_RESET_VAL;
            cfg_s3_q   <= CFG_RESET_VAL;
        end else if (clk_en_i) begin
            rst_sync_q <= {rst_sync_q[1:0], external_reset_input_n_i};
            cfg_s1_q   <= {bus_active_select_i, bus_config_select_hi_i,
                           bus_config_select_lo_i};
            cfg_s2_q   <= cfg_s1_q;
            cfg_s3_q   <= cfg_s2_q;
        end
    end

    // a change counts once stages two and three agree
    wire logic rst_agree;
    assign rst_agree = rst_sync_q[1] == rst_sync_q[2];

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_lvl_q <= 1'b1;
        end else if (clk_en_i && rst_agree) begin
            rst_lvl_q <= rst_sync_q[2];
        end
    end

    // low-time counter: short glitches on the pin do not reset the part
    logic [RST_CNT_W-1:0] low_cnt_q;
    wire  logic [RST_CNT_W-1:0] low_cnt_d;
    wire  logic           hw_reset;
    localparam logic [RST_CNT_W-1:0] RST_MIN_CNT = RST_CNT_W'(RST_MIN_CYCLES);

    assign hw_reset  = low_cnt_q == RST_MIN_CNT;
    assign low_cnt_d = rst_lvl_q ? '0 :
                       (hw_reset ? low_cnt_q : low_cnt_q + 1'b1);

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            low_cnt_q <= '0;
        end else if (clk_en_i) begin
            low_cnt_q <= low_cnt_d;
        end
    end

    // reset sequencing
    rbms_state_e state_q;
    rbms_state_e state_d;
    wire logic   any_reset;
    assign any_reset = hw_reset || sw_reset_i || wdt_reset_i;

    always_comb begin
        state_d = state_q;
        case (state_q)
            RBMS_ST_RESET: begin
                if (!any_reset) begin
                    state_d = RBMS_ST_INIT;
                end
            end
            RBMS_ST_INIT: begin
                if (any_reset) begin
                    state_d = RBMS_ST_RESET;
                end else if (end_of_init_instruction_i) begin
                    state_d = RBMS_ST_RUN;
                end
            end
            RBMS_ST_RUN: begin
                if (any_reset) begin
                    state_d = RBMS_ST_RESET;
                end
            end
            default: state_d = RBMS_ST_RESET;
        endcase
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q <= RBMS_ST_RESET;
        end else if (clk_en_i) begin
            state_q <= state_d;
        end
    end

    // straps are captured only while a hardware reset is held, and only
    // once the last two synchroniser stages agree on the strap levels
    logic [2:0] cfg_q;
    wire  logic [2:0] cfg_d;
    wire  logic       cfg_take;
    assign cfg_take = hw_reset && (cfg_s2_q == cfg_s3_q);
    assign cfg_d    = cfg_take ? cfg_s3_q : cfg_q;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cfg_q <= CFG_RESET_VAL;
        end else if (clk_en_i) begin
            cfg_q <= cfg_d;
        end
    end

    // mode decode
    function automatic logic is_ext_bus(input logic [2:0] code);
        return !code[2];
    endfunction

    wire logic ext_bus_d;
    wire logic rsvd_d;
    wire logic in_reset_d;
    assign ext_bus_d  = is_ext_bus(cfg_d);
    assign rsvd_d     = cfg_d[2] && (cfg_d[1:0] != 2'h0);
    assign in_reset_d = state_d != RBMS_ST_RUN;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            internal_reset_indication_n_o <= 1'b0;
            core_reset_n_o                <= 1'b0;
            bus_mode_o                    <= RBMS_SINGLE;
            ext_bus_o                     <= 1'b0;
            mode_reserved_o               <= 1'b0;
        end else if (clk_en_i) begin
            internal_reset_indication_n_o <= !in_reset_d;
            core_reset_n_o                <= state_d != RBMS_ST_RESET;
            bus_mode_o                    <= rbms_mode_e'(cfg_d);
            ext_bus_o                     <= ext_bus_d;
            mode_reserved_o               <= rsvd_d;
        end
    end

    // segment port
    rbms_port_if pif ();
    assign pif.dir      = port_dir_i;
    assign pif.data     = port_data_i;
    assign pif.seg_en   = is_ext_bus(cfg_q);
    assign pif.seg_addr = {seg_addr_high_i, seg_addr_low_i};

    rbms_seg_port u_port (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .clk_en_i  (clk_en_i),
        .pif       (pif.port)
    );

    assign segment_port_out_o = pif.pin_out;
    assign segment_port_oe_o  = pif.pin_oe;

    a_strap_hold: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        clk_en_i && !hw_reset |=> cfg_q == $past(cfg_q))
        else $error("captured mode changed outside reset");

    a_rst_ind_low: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        clk_en_i && any_reset |=> !internal_reset_indication_n_o)
        else $error("reset indication high during reset");

    a_end_of_init_instruction_release: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        $rose(internal_reset_indication_n_o) |->
            $past(end_of_init_instruction_i))
        else $error("reset indication released without end of init");

    a_hw_reset_len: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        $rose(hw_reset) |-> !$past(rst_lvl_q))
        else $error("hardware reset without low reset input");

    a_seg_drive: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        clk_en_i && pif.seg_en && $past(clk_en_i)
        |=> segment_port_out_o == $past(pif.seg_addr))
        else $error("segment address not on port");

    a_dir_oe: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        clk_en_i |=> segment_port_oe_o == $past(port_dir_i))
        else $error("port enable does not follow direction");

    a_mode_decode: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        ext_bus_o |-> bus_mode_o < RBMS_SINGLE)
        else $error("external bus flag with non-bus mode");

    a_capture_now: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        clk_en_i && cfg_take |=> cfg_q == $past(cfg_s3_q))
        else $error("straps not captured during reset");
endmodule

// >>> src/rbms_pkg.sv
// Purpose: shared constants and types of the reset and bus mode select block
// Assumes: 250 MHz core clock
// Notes:   mode codes follow the three configuration straps, bus-active first
package rbms_pkg;

    localparam int unsigned CLK_PERIOD_NS   = 4;
    // least low time of the external reset input, in ns
    localparam int unsigned RST_MIN_LOW_NS  = 100;
    localparam int unsigned RST_MIN_CYCLES  =
        (RST_MIN_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RST_CNT_W       = 8;

    localparam int unsigned SEG_PORT_W      = 2;
    localparam int unsigned CFG_W           = 3;
    localparam logic [2:0]  CFG_RESET_VAL   = 3'h4;
    localparam logic [1:0]  PORT_RESET_VAL  = 2'h0;

    typedef enum logic [2:0] {
        RBMS_DEMUX8  = 3'h0,
        RBMS_MUX8    = 3'h1,
        RBMS_MUX16   = 3'h2,
        RBMS_DEMUX16 = 3'h3,
        RBMS_SINGLE  = 3'h4,
        RBMS_RSVD5   = 3'h5,
        RBMS_RSVD6   = 3'h6,
        RBMS_RSVD7   = 3'h7
    } rbms_mode_e;

    typedef enum {
        RBMS_ST_RUN,
        RBMS_ST_RESET,
        RBMS_ST_INIT
    } rbms_state_e;

endpackage

// >>> src/rbms_port_if.sv
// Purpose: carries the segment port controls between top and port slice
// Assumes: one clock domain
// Notes:   pins are split into output and output enable, with no pin input
`timescale 1ns/10ps
interface rbms_port_if;
    logic [1:0] dir;
    logic [1:0] data;
    logic       seg_en;
    logic [1:0] seg_addr;
    logic [1:0] pin_out;
    logic [1:0] pin_oe;

    modport ctl  (output dir, data, seg_en, seg_addr, input pin_out, pin_oe);
    modport port (input dir, data, seg_en, seg_addr, output pin_out, pin_oe);
endinterface

// >>> src/rbms_seg_port.sv
// Purpose: two-pin segment port driver
// Assumes: controls come from registers on the same clock
// Notes:   output side registered so top outputs come from flops
`timescale 1ns/10ps
module rbms_seg_port
    import rbms_pkg::*;
(
    // clock and reset
    input  wire logic clk_i,
    input  wire logic reset_n_i,
    input  wire logic clk_en_i,
    // controls
    rbms_port_if.port pif
);
    wire logic [1:0] out_d;
    wire logic [1:0] oe_d;
    logic      [1:0] out_q;
    logic      [1:0] oe_q;

    // segment address drives the pin data when a bus mode is active
    assign out_d = pif.seg_en ? pif.seg_addr : pif.data;
    // a pin set as input floats its driver
    assign oe_d  = pif.dir;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            out_q <= PORT_RESET_VAL;
            oe_q  <= PORT_RESET_VAL;
        end else if (clk_en_i) begin
            out_q <= out_d;
            oe_q  <= oe_d;
        end
    end

    assign pif.pin_out = out_q;
    assign pif.pin_oe  = oe_q;

    a_input_floats: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        clk_en_i |=> (oe_q & ~$past(pif.dir)) == 2'h0)
        else $error("port pin driven while set as input");
endmodule

// >>> dv/rbms_board_model.sv
// Purpose: board model: reset circuit and configuration straps
// Assumes: one clock; pins change just after the falling edge
// Notes:   reset pin idles high, as its pull-up would hold it
`timescale 1ns/10ps
module rbms_board_model #(
    parameter bit ROMLESS = 1'b0
) (
    // clock
    input  wire logic clk_i,
    // pins
    output logic      rst_pin_n_o,
    output logic      bus_act_o,
    output logic      cfg_hi_o,
    output logic      cfg_lo_o
);
    initial begin
        rst_pin_n_o = 1'b1;
        {bus_act_o, cfg_hi_o, cfg_lo_o} = 3'h4;
    end

    // parts without program memory never choose single chip mode
    task automatic set_straps(input logic [2:0] code);
        @(negedge clk_i);
        bus_act_o = ROMLESS ? 1'b0 : code[2];
        {cfg_hi_o, cfg_lo_o} = code[1:0];
    endtask

    task automatic pulse(input int cycles);
        @(negedge clk_i);
        rst_pin_n_o = 1'b0;
        repeat (cycles) @(negedge clk_i);
        rst_pin_n_o = 1'b1;
    endtask
endmodule

// >>> dv/testbench.sv
// Purpose: self-checking bench of the reset and bus mode select block
// Assumes: inputs driven at the falling edge, outputs read there too
// Notes:   straps only recaptured by a pin reset, not by sw or watchdog
`timescale 1ns/10ps
module testbench;
    import rbms_pkg::*;
    logic       clk, rst_n, pin_n, b_act, c_hi, c_lo;
    logic       sw, wdt, end_of_init_instruction, a16, a17, ind_n, core_n, ext, rsvd;
    logic [1:0] dir, data, pout, poe;
    logic [2:0] code;
    logic [31:0] rnd;
    rbms_mode_e mode;
    int         miscompares, cmp_count, seed, i, k;

    rbms_board_model board (.clk_i(clk), .rst_pin_n_o(pin_n),
        .bus_act_o(b_act), .cfg_hi_o(c_hi), .cfg_lo_o(c_lo));

    rbms_top DUT (.clk_i(clk), .reset_n_i(rst_n), .clk_en_i(1'b1),
        .external_reset_input_n_i(pin_n), .bus_active_select_i(b_act),
        .bus_config_select_hi_i(c_hi), .bus_config_select_lo_i(c_lo),
        .sw_reset_i(sw), .wdt_reset_i(wdt),
        .end_of_init_instruction_i(end_of_init_instruction), .port_dir_i(dir),
        .port_data_i(data), .seg_addr_low_i(a16), .seg_addr_high_i(a17),
        .internal_reset_indication_n_o(ind_n), .core_reset_n_o(core_n),
        .bus_mode_o(mode), .ext_bus_o(ext), .mode_reserved_o(rsvd),
        .segment_port_out_o(pout), .segment_port_oe_o(poe));

    function automatic logic [1:0] exp_out(input logic [2:0] c,
        input logic [1:0] d, input logic hi, input logic lo);
        return c[2] ? d : {hi, lo};
    endfunction

    task automatic final_report();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk_bit(input string n, input logic e, input logic g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %b seen %b", n, e, g);
        end
    endtask

    task automatic chk_vec(input string n, input logic [2:0] e,
        input logic [2:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    // bounded wait for the core reset to be released
    task automatic wait_run();
        int n;
        for (n = 0; n < 20 && core_n !== 1'b1; n++) begin
            @(negedge clk);
        end
        if (core_n !== 1'b1) begin
            miscompares++;
            $display("mismatch core_n release expected 1 seen %b", core_n);
            final_report();
        end
    endtask

    task automatic end_init();
        @(negedge clk);
        end_of_init_instruction = 1'b1;
        @(negedge clk);
        end_of_init_instruction = 1'b0;
        @(negedge clk);
    endtask

    task automatic port_step(input logic [2:0] c);
        logic [31:0] r;
        r = $random(seed);
        @(negedge clk);
        dir = r[1:0];
        data = r[3:2];
        {a17, a16} = r[5:4];
        repeat (2) @(negedge clk);
        chk_vec("port oe", {1'b0, dir}, {1'b0, poe});
        chk_vec("port out", {1'b0, exp_out(c, data, a17, a16)},
            {1'b0, pout});
    endtask

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial begin
        #200000;
        miscompares++;
        final_report();
    end

    initial begin
        seed = 52295;
        {rst_n, sw, wdt, end_of_init_instruction, a16, a17} = 6'h0;
        dir = 2'h0;
        data = 2'h0;
        miscompares = 0;
        cmp_count = 0;
        repeat (16) @(negedge clk);
        chk_bit("ind_n chip reset", 1'b0, ind_n);
        chk_vec("mode chip reset", CFG_RESET_VAL, mode);
        rst_n = 1'b1;
        for (i = 0; i < 8; i++) begin
            code = i[2:0];
            board.set_straps(code);
            board.pulse(RST_MIN_CYCLES + 12);
            chk_bit("core_n pin reset", 1'b0, core_n);
            chk_bit("ind_n pin reset", 1'b0, ind_n);
            wait_run();
            repeat (2) @(negedge clk);
            chk_vec("mode", code, mode);
            chk_bit("ext", ~code[2], ext);
            chk_bit("rsvd", code >= 3'h5, rsvd);
            rnd = $random(seed);
            board.set_straps(rnd[2:0]);
            repeat (8) @(negedge clk);
            chk_vec("mode held", code, mode);
            chk_bit("ind_n before init", 1'b0, ind_n);
            for (k = 0; k < 4; k++) begin
                port_step(code);
            end
            end_init();
            chk_bit("ind_n after init", 1'b1, ind_n);
        end
        // one cycle short of the least low time: must be ignored
        board.pulse(RST_MIN_CYCLES - 1);
        repeat (40) @(negedge clk);
        chk_bit("ind_n short pulse", 1'b1, ind_n);
        chk_vec("mode short pulse", 3'h7, mode);
        for (i = 0; i < 2; i++) begin
            @(negedge clk);
            sw = (i == 0);
            wdt = (i == 1);
            repeat (4) @(negedge clk);
            chk_bit("ind_n sw wdt", 1'b0, ind_n);
            chk_bit("core_n sw wdt", 1'b0, core_n);
            sw = 1'b0;
            wdt = 1'b0;
            wait_run();
            chk_bit("ind_n after sw wdt", 1'b0, ind_n);
            chk_vec("mode after sw wdt", 3'h7, mode);
            end_init();
            chk_bit("ind_n released", 1'b1, ind_n);
        end
        final_report();
    end
endmodule
